// ### src/ppo_config.v
// Serial frame decoder and settings store for PWM period and phase delay
`timescale 1ns/1ps
`default_nettype none
`include "ppo_consts.vh"
module ppo_config #(
    parameter NCH = 8
) (
    input  wire           i_mclk,
    input  wire           i_reset,
    input  wire           i_sclk,
    input  wire           i_cs_n,
    input  wire           i_mosi,
    input  wire           i_align_strobe,
    input  wire           i_direct_mode,
    output reg            o_miso,
    output wire [NCH-1:0] o_sample_tick,
    output wire [NCH-1:0] o_period_start,
    output wire [NCH-1:0] o_phase_mark,
    output reg  [NCH-1:0] o_avg_discard
);
    // Two-stage synchronisers for pins
    reg  [1:0]  sclk_s_r;
    reg  [1:0]  cs_s_r;
    reg  [1:0]  mosi_s_r;
    reg  [1:0]  aln_s_r;
    reg  [1:0]  dm_s_r;
    reg         sclk_d_r;
    reg         aln_d_r;
    reg  [31:0] shift_r;
    reg  [5:0]  bitcnt_r;
    reg  [31:0] reply_r;
    reg  [4:0]  delay_r  [0:NCH-1];
    reg  [1:0]  mcode_r  [0:NCH-1];
    reg  [13:0] nclk_r   [0:NCH-1];
    reg  [31:0] reply_nxt;
    wire        cs_act   = ~cs_s_r[1];
    wire        rise     = sclk_s_r[1] & ~sclk_d_r;
    wire        fall     = ~sclk_s_r[1] & sclk_d_r;
    wire        align    = aln_s_r[1] & ~aln_d_r; // RULE3
    wire [31:0] frame    = {shift_r[30:0], mosi_s_r[1]};
    wire        last_bit = rise & cs_act & (bitcnt_r == 6'h1F);
    wire        is_dly   = frame[`PPO_CODE7_HI:`PPO_CODE7_LO] == `PPO_DELAY_CODE; // RULE1
    wire        is_per   = frame[`PPO_CODE4_HI:`PPO_CODE4_LO] == `PPO_PERIOD_CODE; // RULE5
    wire        wr       = frame[`PPO_RW_BIT];
    wire [2:0]  idx      = frame[`PPO_IDX_HI:`PPO_IDX_LO];
    integer     k;
    always @* begin
        reply_nxt = 32'h00000000;
        if (is_dly) begin
            // RULE4
            reply_nxt[`PPO_CODE7_HI:`PPO_CODE7_LO] = `PPO_DELAY_CODE;
            reply_nxt[19:0] = {delay_r[4], delay_r[5], delay_r[6], delay_r[7]};
        end else if (is_per) begin
            // RULE10
            reply_nxt[`PPO_CODE4_HI:`PPO_CODE4_LO] = `PPO_PERIOD_CODE;
            reply_nxt[`PPO_IDX_HI:`PPO_IDX_LO]     = idx;
            reply_nxt[`PPO_AVG_BIT]                = o_avg_discard[idx];
            reply_nxt[`PPO_M_HI:`PPO_M_LO]         = mcode_r[idx];
            reply_nxt[`PPO_N_HI:`PPO_N_LO]         = nclk_r[idx];
        end
    end
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sclk_s_r      <= 2'h0;
            cs_s_r        <= 2'h3;
            mosi_s_r      <= 2'h0;
            aln_s_r       <= 2'h0;
            dm_s_r        <= 2'h0;
            sclk_d_r      <= 1'b0;
            aln_d_r       <= 1'b0;
            shift_r       <= 32'h00000000;
            bitcnt_r      <= 6'h00;
            reply_r       <= 32'h00000000;
            o_miso        <= 1'b0;
            o_avg_discard <= {NCH{1'b0}}; // RULE6
            for (k = 0; k < NCH; k = k + 1) begin
                delay_r[k] <= 5'h00; // RULE2
                mcode_r[k] <= `PPO_M_RESET;
                nclk_r[k]  <= `PPO_N_RESET; // RULE8
            end
        end else begin
            sclk_s_r <= {sclk_s_r[0], i_sclk};
            cs_s_r   <= {cs_s_r[0], i_cs_n};
            mosi_s_r <= {mosi_s_r[0], i_mosi};
            aln_s_r  <= {aln_s_r[0], i_align_strobe};
            dm_s_r   <= {dm_s_r[0], i_direct_mode};
            sclk_d_r <= sclk_s_r[1];
            aln_d_r  <= aln_s_r[1];
            if (!cs_act) begin
                bitcnt_r <= 6'h00;
                o_miso   <= reply_r[31];
            end else if (rise) begin
                shift_r  <= frame;
                bitcnt_r <= (bitcnt_r == 6'h1F) ? 6'h00 : bitcnt_r + 6'h01;
            end else if (fall && bitcnt_r != 6'h00) begin
                // Fall after the 32nd rise must not shift the freshly loaded reply
                reply_r <= {reply_r[30:0], 1'b0};
                o_miso  <= reply_r[30];
            end
            if (last_bit) begin
                reply_r <= reply_nxt;
                if (wr && is_dly) begin // RULE11
                    delay_r[4] <= frame[19:15]; // RULE2
                    delay_r[5] <= frame[14:10];
                    delay_r[6] <= frame[9:5];
                    delay_r[7] <= frame[4:0];
                end
                if (wr && is_per) begin // RULE11
                    o_avg_discard[idx] <= frame[`PPO_AVG_BIT]; // RULE6
                    mcode_r[idx]       <= frame[`PPO_M_HI:`PPO_M_LO]; // RULE7
                    nclk_r[idx]        <= frame[`PPO_N_HI:`PPO_N_LO]; // RULE8
                end
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            ppo_channel_timer u_tmr (
                .i_mclk            (i_mclk),
                .i_reset           (i_reset),
                .i_align           (align),
                .i_direct_mode     (dm_s_r[1]),
                .i_clks_per_sample (nclk_r[g]),
                .i_m_code          (mcode_r[g]),
                .i_delay           (delay_r[g]),
                .o_sample_tick     (o_sample_tick[g]),
                .o_period_start    (o_period_start[g]),
                .o_phase_mark      (o_phase_mark[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ### src/ppo_consts.vh
// Constants for the PWM period and phase-delay configuration block
// Summary of operation
// RULE1: Code 0000111 in bits 30:24 addresses delays of channels 4-7; bit 31 writes.
// RULE2: Five-bit delay per channel 4..7 at 19:15,14:10,9:5,4:0, units period/32, reset zero.
// RULE3: Controller pulses the alignment strobe after reset to synchronise phase delays.
// RULE4: Delay reply has bit 31 and bits 23:20 low, code and fields echoed.
// RULE5: Code 0001 in bits 30:27 addresses period settings of channel in 26:24.
// RULE6: Bit 16 selects averaging: zero all samples, one discards post-transition samples.
// RULE7: Bits 15:14 give samples per period 32,64,128; code 11 gives 512 or 128.
// RULE8: Bits 13:0 hold clocks between samples, reset 625.
// RULE9: PWM period is clocks-per-sample times samples-per-period; sample every N clocks.
// RULE10: Period reply has bit 31 and 23:17 low, echoes code, index and settings.
// RULE11: Writes change only addressed channels; reads change nothing.
`ifndef PPO_CONSTS_VH
`define PPO_CONSTS_VH
`define PPO_RW_BIT        31
`define PPO_CODE7_HI      30
`define PPO_CODE7_LO      24
`define PPO_CODE4_HI      30
`define PPO_CODE4_LO      27
`define PPO_DELAY_CODE    7'h07
`define PPO_PERIOD_CODE   4'h1
`define PPO_IDX_HI        26
`define PPO_IDX_LO        24
`define PPO_AVG_BIT       16
`define PPO_M_HI          15
`define PPO_M_LO          14
`define PPO_N_HI          13
`define PPO_N_LO          0
`define PPO_N_RESET       14'h0271
`define PPO_M_RESET       2'h0
`define PPO_DLY_W         5
`define PPO_DLY_STEPS     5'h1F
`define PPO_CNT_W         24
`endif

// ### src/ppo_channel_timer.v
// Per-channel PWM period, sample tick and phase-delayed pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "ppo_consts.vh"
module ppo_channel_timer (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_align,
    input  wire        i_direct_mode,
    input  wire [13:0] i_clks_per_sample,
    input  wire [1:0]  i_m_code,
    input  wire [4:0]  i_delay,
    output reg         o_sample_tick,
    output reg         o_period_start,
    output reg         o_phase_mark
);
    reg  [13:0] n_cnt_r;
    reg  [9:0]  s_cnt_r;
    reg  [9:0]  m_val;
    reg  [9:0]  mark_at;
    reg  [14:0] dly_prod;
    // Index the sample counter is about to take, so the mark lines up with period start
    wire [9:0]  s_next = (s_cnt_r + 10'h001 >= m_val) ? 10'h000 : s_cnt_r + 10'h001;
    always @* begin
        case (i_m_code) // RULE7
            2'h0:    m_val = 10'h020;
            2'h1:    m_val = 10'h040;
            2'h2:    m_val = 10'h080;
            default: m_val = i_direct_mode ? 10'h200 : 10'h080;
        endcase
        // Delay in 1/32 of period = delay * (M/32) samples
        // Product needs 14 bits (31*512 = 15872); a 10-bit context would wrap for large M
        dly_prod = {5'h00, i_delay} * {5'h00, m_val};
        mark_at  = dly_prod[14:5];
    end
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            n_cnt_r        <= 14'h0000;
            s_cnt_r        <= 10'h000;
            o_sample_tick  <= 1'b0;
            o_period_start <= 1'b0;
            o_phase_mark   <= 1'b0;
        end else begin
            o_sample_tick  <= 1'b0;
            o_period_start <= 1'b0;
            o_phase_mark   <= 1'b0;
            if (i_align) begin
                n_cnt_r <= 14'h0000;
                s_cnt_r <= 10'h000;
            end else if (n_cnt_r + 14'h0001 >= i_clks_per_sample) begin // RULE9
                n_cnt_r       <= 14'h0000;
                o_sample_tick <= 1'b1;
                o_phase_mark  <= (s_next == mark_at); // RULE2
                if (s_cnt_r + 10'h001 >= m_val) begin // RULE9
                    s_cnt_r        <= 10'h000;
                    o_period_start <= 1'b1;
                end else begin
                    s_cnt_r <= s_cnt_r + 10'h001;
                end
            end else begin
                n_cnt_r <= n_cnt_r + 14'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/ppo_config_assertions.sv
// Port checks for the configuration block
`timescale 1ns/1ps
`default_nettype none
module ppo_config_chk #(parameter NCH = 8) (
    input wire logic           i_mclk,
    input wire logic           i_reset,
    input wire logic           i_cs_n,
    input wire logic [NCH-1:0] o_sample_tick,
    input wire logic [NCH-1:0] o_period_start,
    input wire logic [NCH-1:0] o_phase_mark,
    input wire logic [NCH-1:0] o_avg_discard
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    tick_gap_a: assert property (o_sample_tick[0] |=> !o_sample_tick[0] [*8]) else $error("tick gap");
    tick_alive_a: assert property (o_sample_tick[0] |-> ##[1:700] o_sample_tick[0]) else $error("tick lost");
    start_gap_a: assert property (o_period_start[0] |=> !o_period_start[0] [*8]) else $error("start gap");
    last_start_a: assert property (o_period_start[7] |=> !o_period_start[7] [*8]) else $error("start7");
    mark_gap_a: assert property (o_phase_mark[7] |=> !o_phase_mark[7] [*8]) else $error("mark gap");
    side_tick_a: assert property (o_sample_tick[3] |=> !o_sample_tick[3] [*8]) else $error("tick3 gap");
    avg_reset_a: assert property ($fell(i_reset) |-> o_avg_discard == '0) else $error("avg reset");
    avg_quiet_a: assert property (i_cs_n [*8] |=> $stable(o_avg_discard)) else $error("avg moved");
    cover property (o_period_start[2]);
    cover property (o_phase_mark[4]);
    cover property ($rose(o_avg_discard[2]));
endmodule
bind ppo_config ppo_config_chk #(.NCH(NCH)) u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_cs_n(i_cs_n),
    .o_sample_tick(o_sample_tick), .o_period_start(o_period_start), .o_phase_mark(o_phase_mark),
    .o_avg_discard(o_avg_discard));
`default_nettype wire

// ### test/ppo_spi_master.sv
// Behavioural serial master standing in for the controller
`timescale 1ns/1ps
`default_nettype none
module ppo_spi_master (
    output logic     o_sclk = 1'b0,
    output logic     o_cs_n = 1'b1,
    output logic     o_mosi = 1'b0,
    input wire logic i_miso
);
    // Clock stands low between frames; odd start offset keeps it off the main clock phase
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        #7 o_cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_mosi = tx[i];
            #80 o_sclk = 1'b1;
            rx[i] = i_miso;
            #80 o_sclk = 1'b0;
        end
        #80 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #400;
    endtask
endmodule
`default_nettype wire

// ### test/ppo_config_tb.sv
// Self-checking bench for the period and phase-delay configuration block
`timescale 1ns/1ps
`default_nettype none
module ppo_config_tb;
    logic        i_mclk = 1'b0;
    logic        i_reset = 1'b1;
    logic        i_align_strobe = 1'b0;
    logic        i_direct_mode = 1'b0;
    wire         sclk, cs_n, mosi, miso;
    wire [7:0]   tick, pstart, mark, avg;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n;
    int          mv[5] = '{32, 64, 128, 128, 512};
    logic [31:0] rx;
    always #10 i_mclk = ~i_mclk;
    ppo_spi_master i_master (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
    ppo_config #(.NCH(8)) i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
        .i_align_strobe(i_align_strobe), .i_direct_mode(i_direct_mode), .o_miso(miso), .o_sample_tick(tick),
        .o_period_start(pstart), .o_phase_mark(mark), .o_avg_discard(avg));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Reply arrives one frame late, so exp belongs to the previous frame
    task automatic xf(input logic [31:0] tx, input logic [31:0] exp, input bit on);
        @(negedge i_mclk);
        i_master.xfer(tx, rx);
        if (on)
            chk(rx, exp);
    endtask
    task automatic complete_run;
        $display("Counts: %0d mismatches, %0d comparisons", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(negedge i_mclk);
        i_reset = 1'b0;
        repeat (4) @(negedge i_mclk);
        i_align_strobe = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_align_strobe = 1'b0;
        xf(32'h0D00_0000, 32'h0, 0);
        xf(32'h0700_0000, 32'h0D00_0271, 1);
        xf(32'h87FF_860A, 32'h0700_0000, 1);
        xf(32'h0700_0000, 32'h0, 0);
        xf(32'h8AFF_C010, 32'h070F_860A, 1);
        xf(32'h0A00_0000, 32'h0, 0);
        xf(32'h0B00_0000, 32'h0A01_C010, 1);
        xf(32'h0700_0000, 32'h0B00_0271, 1);
        xf(32'h7F00_0000, 32'h070F_860A, 1);
        xf(32'h0B00_0000, 32'h0, 1);
        chk({24'h0, avg}, 32'h04);
        @(posedge i_mclk iff tick[0]);
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (!tick[0]);
        chk(n, 625);
        @(posedge i_mclk iff pstart[5]);
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (!mark[5]);
        chk(n, 625);
        $display("Frame tests done");
        for (int k = 0; k < 5; k++) begin
            @(negedge i_mclk);
            i_direct_mode = (k == 4);
            xf(32'h8A00_0010 | ((k > 3 ? 3 : k) << 14), 32'h0, 0);
            repeat (2) @(posedge i_mclk iff pstart[2]);
            n = 0;
            do begin
                @(posedge i_mclk);
                n++;
            end while (!pstart[2]);
            chk(n, 16 * mv[k]);
        end
        $display("Period tests done");
        complete_run();
    end
endmodule
`default_nettype wire
